// file: logic/hfc_fifo.v
`timescale 1ns/10ps
module hfc_fifo #(
   parameter WIDTH = 10,
   parameter AW = 7
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Fill side
   input wire wr_en,
   input wire [WIDTH-1:0] wr_data,
   // Drain side
   input wire rd_en,
   output wire [WIDTH-1:0] rd_data,
   // Fill state
   output wire [AW:0] count,
   output wire empty,
   output wire full
);
   reg [WIDTH-1:0] mem [0:(1<<AW)-1];
   reg [AW:0] wp;
   reg [AW:0] rp;
   wire do_wr;
   wire do_rd;

   assign count = wp - rp;
   assign empty = (wp == rp);
   assign full = (count[AW] == 1'b1);
   assign do_wr = wr_en & ~full;
   assign do_rd = rd_en & ~empty;
   assign rd_data = mem[rp[AW-1:0]];

   always @(posedge clk) begin
      if (do_wr) begin
         mem[wp[AW-1:0]] <= wr_data;
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         wp <= {(AW+1){1'b0}};
         rp <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            wp <= wp + 1'b1;
         end
         if (do_rd) begin
            rp <= rp + 1'b1;
         end
      end
   end
endmodule

// file: logic/hfc_regs.vh
`ifndef HFC_REGS_VH
`define HFC_REGS_VH
// Register offsets
`define HFC_ADDR_FIFO 5'h12
`define HFC_ADDR_CTRL1 5'h13
`define HFC_ADDR_STAT 5'h14
// Control one fields and reset value
`define HFC_CTRL1_RST 8'h00
`define HFC_C1_ADREC 7
`define HFC_C1_RCV_ON 6
`define HFC_C1_XMIT_ON 5
`define HFC_C1_PKT_END 4
`define HFC_C1_ABORT 3
`define HFC_C1_FILL 2
// Received byte tags
`define HFC_TAG_MID 2'h0
`define HFC_TAG_FIRST 2'h1
`define HFC_TAG_GOOD 2'h2
`define HFC_TAG_BAD 2'h3
// Transmit level codes
`define HFC_LVL_STAT 2'h0
`define HFC_LVL_INT 2'h1
`define HFC_LVL_EMPTY 2'h2
`define HFC_LVL_LOW 2'h3
// Line patterns
`define HFC_FLAG 8'h7E
`define HFC_MARK 8'hFF
`define HFC_ABORT_PAT 8'h7F
`define HFC_GA_PAT 8'hFE
`define HFC_ALL_CALL 7'h7F
// Frame check sequence
`define HFC_CRC_INIT 16'hFFFF
`define HFC_CRC_POLY 16'h8408
`define HFC_CRC_GOOD 16'hF0B8
// Bit counts
`define HFC_IDLE_ONES 4'hF
`define HFC_STUFF_ONES 3'h5
`define HFC_ABORT_ONES 3'h7
`define HFC_FLAG_SKIP 4'h7
`endif

// file: logic/hfc_top.v
// Summary of operation
// R1: Receive port read returns next byte; its tags show in status.
// R2: Level status is registered, changing a cycle after the access.
// R3: With address match on, keep only own-address or all-call packets.
// R4: Receive enable starts the receiver hunting flags at once.
// R5: Receive disable lets the current packet finish, then stops.
// R6: Transmit enable starts at once: data, else idle or fill.
// R7: Transmit disable lets the current packet finish, then stops.
// R8: End tag marks next written byte as last; check sequence follows.
// R9: End and abort tags clear after the next transmit write.
// R10: Abort tag marks next written byte; its packet is aborted.
// R11: Fill select: zero idle ones, one flags; only with queue empty.
// R12: Host writes zeros into the two low reserved control bits.
// R13: Interrupt summary sets on unmasked event, clears on status read.
// R14: Idle channel sets after fifteen or more consecutive ones.
// R15: Receive tags: 00 middle, 01 first, 10 good end, 11 bad end.
// R16: Transmit level: 00 status, 01 threshold, 10 empty, 11 below.
// R17: Transmit entries store the byte plus both tags, ten bits.
// R18: Each receive port read advances to the following byte.
`timescale 1ns/10ps
`include "hfc_regs.vh"
module hfc_top #(
   parameter AW = 7,
   parameter TX_STAT_LEVEL = 8'd112,
   parameter TX_INT_LEVEL = 8'd16
) (
   // Clock and reset
   input wire CLK,
   input wire SYS_RST,
   // Register bus
   input wire [4:0] ADDR,
   input wire CS,
   input wire RD,
   input wire WR,
   input wire [7:0] WDATA,
   output reg [7:0] RDATA,
   // Companion registers and interrupt logic
   input wire [6:0] RECOG_ADDR,
   input wire IRQ_EVENT,
   input wire INT_STAT_READ,
   // Receive line
   input wire RX_BIT,
   input wire RX_BIT_EN,
   output reg RX_GO_AHEAD,
   output wire RX_CLK_ON,
   // Transmit line
   input wire TX_BIT_EN,
   output reg TX_LINE,
   output wire TX_CLK_ON
);
   localparam T_OFF = 3'd0;
   localparam T_IDLE = 3'd1;
   localparam T_DATA = 3'd2;
   localparam T_FCS1 = 3'd3;
   localparam T_FCS2 = 3'd4;
   localparam T_CLOSE = 3'd5;

   function [15:0] crc_bit;
      input [15:0] c;
      input b;
      begin
         crc_bit = (c >> 1) ^ ((c[0] ^ b) ? `HFC_CRC_POLY : 16'h0000);
      end
   endfunction

   function [15:0] crc_byte;
      input [15:0] c;
      input [7:0] d;
      integer i;
      begin
         crc_byte = c;
         for (i = 0; i < 8; i = i + 1) begin
            crc_byte = crc_bit(crc_byte, d[i]);
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Register bus
   reg [7:0] ctrl;
   reg intgen;
   reg [1:0] tx_level;
   reg [1:0] rx_tag;
   reg [3:0] idle_cnt;
   wire wr_fifo = CS & WR & (ADDR == `HFC_ADDR_FIFO);
   wire wr_ctrl = CS & WR & (ADDR == `HFC_ADDR_CTRL1);
   wire rd_fifo = CS & RD & (ADDR == `HFC_ADDR_FIFO);
   wire [9:0] rxq_head;
   wire rxq_empty;
   wire [AW:0] txq_count;
   wire txq_empty;

   always @(posedge CLK) begin
      if (SYS_RST) begin
         ctrl <= `HFC_CTRL1_RST;
      end else if (wr_ctrl) begin
         ctrl <= WDATA;
      end else if (wr_fifo) begin
         ctrl[`HFC_C1_PKT_END] <= 1'b0; // [R9]
         ctrl[`HFC_C1_ABORT] <= 1'b0; // [R9]
      end
   end

   always @(posedge CLK) begin
      if (SYS_RST) begin
         RDATA <= 8'h00;
      end else if (CS & RD) begin
         case (ADDR)
            `HFC_ADDR_FIFO: RDATA <= rxq_head[7:0]; // [R1]
            `HFC_ADDR_CTRL1: RDATA <= ctrl;
            `HFC_ADDR_STAT: RDATA <= {intgen, (idle_cnt == `HFC_IDLE_ONES),
               rx_tag, tx_level, 2'h0}; // [R1] [R14]
            default: RDATA <= 8'h00;
         endcase
      end
   end

   // Interrupt summary: a new event wins over the clearing read
   always @(posedge CLK) begin
      if (SYS_RST) begin
         intgen <= 1'b0;
      end else if (IRQ_EVENT) begin
         intgen <= 1'b1; // [R13]
      end else if (INT_STAT_READ) begin
         intgen <= 1'b0; // [R13]
      end
   end

   // Level and tag status settle one cycle after the access
   always @(posedge CLK) begin
      if (SYS_RST) begin
         tx_level <= `HFC_LVL_EMPTY;
         rx_tag <= `HFC_TAG_MID;
      end else begin
         rx_tag <= rxq_head[9:8]; // [R2] [R15]
         if (txq_empty) begin
            tx_level <= `HFC_LVL_EMPTY; // [R16] [R2]
         end else if (txq_count >= TX_STAT_LEVEL) begin
            tx_level <= `HFC_LVL_STAT; // [R16]
         end else if (txq_count >= TX_INT_LEVEL) begin
            tx_level <= `HFC_LVL_INT; // [R16]
         end else begin
            tx_level <= `HFC_LVL_LOW; // [R16]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receiver
   reg rx_in_frame;
   reg [7:0] rsh;
   reg [2:0] r_ones;
   reg [2:0] d_ones;
   reg [3:0] rskip;
   reg [7:0] rbyte;
   reg [2:0] rbits;
   reg [15:0] rcrc;
   reg [7:0] p0;
   reg [7:0] p1;
   reg [7:0] p2;
   reg [1:0] pcnt;
   reg first;
   reg drop;
   reg rxq_wr;
   reg [9:0] rxq_word;
   wire rx_run = ctrl[`HFC_C1_RCV_ON] | rx_in_frame; // [R4] [R5]
   wire rx_step = RX_BIT_EN & rx_run;
   wire out_bit = rsh[0];
   wire addr_ok = ~ctrl[`HFC_C1_ADREC] | (p0[7:1] == RECOG_ADDR) |
      (p0[7:1] == `HFC_ALL_CALL); // [R3]
   wire frame_good = (rbits == 3'd0) & (rcrc == `HFC_CRC_GOOD);
   wire keep_p0 = ~drop & (~first | addr_ok);
   wire byte_done = (rbits == 3'd7);
   wire [7:0] new_byte = {out_bit, rbyte[7:1]};

   assign RX_CLK_ON = rx_run;

   always @(posedge CLK) begin
      if (SYS_RST) begin
         rx_in_frame <= 1'b0;
         rsh <= 8'h00;
         r_ones <= 3'h0;
         d_ones <= 3'h0;
         rskip <= 4'h0;
         rbyte <= 8'h00;
         rbits <= 3'h0;
         rcrc <= `HFC_CRC_INIT;
         p0 <= 8'h00;
         p1 <= 8'h00;
         p2 <= 8'h00;
         pcnt <= 2'h0;
         first <= 1'b1;
         drop <= 1'b0;
         rxq_wr <= 1'b0;
         rxq_word <= 10'h000;
         idle_cnt <= 4'h0;
         RX_GO_AHEAD <= 1'b0;
      end else begin
         rxq_wr <= 1'b0;
         RX_GO_AHEAD <= 1'b0;
         if (rx_step) begin
            rsh <= {RX_BIT, rsh[7:1]};
            r_ones <= RX_BIT ? ((r_ones == `HFC_ABORT_ONES) ? r_ones :
               r_ones + 1'b1) : 3'h0;
            if (RX_BIT & (idle_cnt != `HFC_IDLE_ONES)) begin
               idle_cnt <= idle_cnt + 1'b1; // [R14]
            end else if (~RX_BIT) begin
               idle_cnt <= 4'h0; // [R14]
            end
            if (rsh == `HFC_GA_PAT) begin
               RX_GO_AHEAD <= 1'b1; // [R4]
            end
            if (rsh == `HFC_FLAG) begin
               // Closing flag ends any frame, then a new one may open
               if (rx_in_frame & (pcnt == 2'd3) & keep_p0) begin
                  rxq_wr <= 1'b1;
                  rxq_word <= {(frame_good ? `HFC_TAG_GOOD : `HFC_TAG_BAD),
                     p0}; // [R15]
               end
               rx_in_frame <= ctrl[`HFC_C1_RCV_ON]; // [R4] [R5]
               rskip <= `HFC_FLAG_SKIP;
               rcrc <= `HFC_CRC_INIT;
               rbits <= 3'h0;
               d_ones <= 3'h0;
               pcnt <= 2'h0;
               first <= 1'b1;
               drop <= 1'b0;
            end else if (RX_BIT & (r_ones == 3'd6)) begin
               if (rx_in_frame & ~first & keep_p0) begin
                  rxq_wr <= 1'b1;
                  rxq_word <= {`HFC_TAG_BAD, p0}; // [R15]
               end
               rx_in_frame <= 1'b0;
            end else if (rx_in_frame & (rskip != 4'h0)) begin
               rskip <= rskip - 1'b1;
            end else if (rx_in_frame) begin
               if ((d_ones == `HFC_STUFF_ONES) & ~out_bit) begin
                  d_ones <= 3'h0;
               end else begin
                  d_ones <= out_bit ? d_ones + 1'b1 : 3'h0;
                  rcrc <= crc_bit(rcrc, out_bit);
                  rbyte <= new_byte;
                  rbits <= rbits + 1'b1;
                  if (byte_done) begin
                     p2 <= new_byte;
                     p1 <= p2;
                     p0 <= p1;
                     if (pcnt != 2'd3) begin
                        pcnt <= pcnt + 1'b1;
                     end else begin
                        first <= 1'b0;
                        drop <= ~keep_p0; // [R3]
                        rxq_wr <= keep_p0; // [R3]
                        rxq_word <= {(first ? `HFC_TAG_FIRST :
                           `HFC_TAG_MID), p0}; // [R15]
                     end
                  end
               end
            end
         end
      end
   end

   hfc_fifo #(.WIDTH(10), .AW(AW)) u_rxq (
      .clk(CLK),
      .rst(SYS_RST),
      .wr_en(rxq_wr),
      .wr_data(rxq_word),
      .rd_en(rd_fifo), // [R18]
      .rd_data(rxq_head),
      .count(),
      .empty(rxq_empty),
      .full()
   );

   ////////////////////////////////////////////////////////////////////////
   // Transmitter
   reg [2:0] tstate;
   reg [7:0] tsh;
   reg [3:0] tcnt;
   reg tstuff;
   reg [2:0] t_ones;
   reg [15:0] tcrc;
   wire [9:0] txq_head;
   wire tload = (tcnt == 4'h0) & ~TX_BIT_EN;
   wire tpop = tload & (tstate == T_DATA) & ~txq_empty;
   wire in_packet = (tstate != T_OFF) & (tstate != T_IDLE);

   assign TX_CLK_ON = ctrl[`HFC_C1_XMIT_ON] | in_packet |
      (tcnt != 4'h0); // [R6] [R7]

   hfc_fifo #(.WIDTH(10), .AW(AW)) u_txq (
      .clk(CLK),
      .rst(SYS_RST),
      .wr_en(wr_fifo),
      .wr_data({ctrl[`HFC_C1_ABORT], ctrl[`HFC_C1_PKT_END], WDATA}), // [R17]
      .rd_en(tpop),
      .rd_data(txq_head),
      .count(txq_count),
      .empty(txq_empty),
      .full()
   );

   always @(posedge CLK) begin
      if (SYS_RST) begin
         tstate <= T_OFF;
         tsh <= `HFC_MARK;
         tcnt <= 4'h0;
         tstuff <= 1'b0;
         t_ones <= 3'h0;
         tcrc <= `HFC_CRC_INIT;
         TX_LINE <= 1'b1;
      end else if (tload) begin
         tcnt <= 4'h8;
         tstuff <= 1'b0;
         case (tstate)
            T_OFF, T_IDLE: begin
               if (~ctrl[`HFC_C1_XMIT_ON]) begin
                  tstate <= T_OFF; // [R7]
                  tsh <= `HFC_MARK;
                  tcnt <= 4'h0;
               end else if (~txq_empty) begin
                  tstate <= T_DATA; // [R6]
                  tsh <= `HFC_FLAG;
                  tcrc <= `HFC_CRC_INIT;
               end else begin
                  tstate <= T_IDLE; // [R11]
                  tsh <= ctrl[`HFC_C1_FILL] ? `HFC_FLAG : `HFC_MARK; // [R11]
               end
            end
            T_DATA: begin
               if (txq_empty | txq_head[9]) begin
                  tstate <= T_IDLE; // [R10]
                  tsh <= `HFC_ABORT_PAT; // [R10]
               end else begin
                  tsh <= txq_head[7:0];
                  tstuff <= 1'b1;
                  tcrc <= crc_byte(tcrc, txq_head[7:0]);
                  if (txq_head[8]) begin
                     tstate <= T_FCS1; // [R8]
                  end
               end
            end
            T_FCS1: begin
               tsh <= ~tcrc[7:0]; // [R8]
               tstuff <= 1'b1;
               tstate <= T_FCS2;
            end
            T_FCS2: begin
               tsh <= ~tcrc[15:8]; // [R8]
               tstuff <= 1'b1;
               tstate <= T_CLOSE;
            end
            T_CLOSE: begin
               tsh <= `HFC_FLAG;
               tstate <= T_IDLE;
            end
            default: begin
               tsh <= `HFC_MARK;
               tstate <= T_OFF;
            end
         endcase
      end else if (TX_BIT_EN & (tcnt != 4'h0)) begin
         if (tstuff & (t_ones == `HFC_STUFF_ONES)) begin
            TX_LINE <= 1'b0;
            t_ones <= 3'h0;
         end else begin
            TX_LINE <= tsh[0];
            tsh <= {1'b1, tsh[7:1]};
            tcnt <= tcnt - 1'b1;
            t_ones <= (tsh[0] & tstuff) ? t_ones + 1'b1 : 3'h0;
         end
      end else if (TX_BIT_EN) begin
         TX_LINE <= 1'b1;
      end
   end
endmodule

// file: sim/hfc_line.sv
`timescale 1ns/10ps
module hfc_line #(
   parameter P = 4
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Line side
   input wire tx_line,
   output reg tx_en,
   output reg rx_en,
   output reg rx_bit
);
   reg [3:0] n;
   reg d1;
   // Bit strobes; sent bit looped back, line toggles between strobes
   always @(posedge clk) begin
      if (rst) begin
         n <= 4'h0;
         tx_en <= 1'h0;
         d1 <= 1'h0;
         rx_en <= 1'h0;
         rx_bit <= 1'h1;
      end else begin
         n <= (n == P - 1) ? 4'h0 : n + 4'h1;
         tx_en <= (n == 4'h0);
         d1 <= tx_en;
         rx_en <= d1;
         rx_bit <= d1 ? tx_line : ~rx_bit;
      end
   end
endmodule

// file: sim/hfc_top_chk.sv
`timescale 1ns/10ps
`include "hfc_regs.vh"
module hfc_top_chk (
   // Clock and reset
   input wire CLK,
   input wire SYS_RST,
   // Register bus
   input wire [4:0] ADDR,
   input wire CS,
   input wire RD,
   input wire WR,
   input wire [7:0] WDATA,
   input wire [7:0] RDATA,
   // Events and lines
   input wire IRQ_EVENT,
   input wire INT_STAT_READ,
   input wire RX_GO_AHEAD,
   input wire RX_CLK_ON,
   input wire TX_BIT_EN,
   input wire TX_LINE,
   input wire TX_CLK_ON
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SYS_RST);
   sequence s_wr13;
      CS && WR && ADDR == `HFC_ADDR_CTRL1;
   endsequence
   sequence s_wr12;
      CS && WR && ADDR == `HFC_ADDR_FIFO;
   endsequence
   sequence s_rd13;
      CS && RD && ADDR == `HFC_ADDR_CTRL1;
   endsequence
   sequence s_rd14;
      CS && RD && ADDR == `HFC_ADDR_STAT;
   endsequence
   ////////////////////////////////////////////////////////////
   a_ctrl_read_back: assert property (s_wr13 ##2 s_rd13
      |=> RDATA == $past(WDATA, 3)) else $error("control readback");
   a_tag_self_clear: assert property (s_wr13 ##2 s_wr12 ##2 s_rd13
      |=> RDATA[4:3] == 2'h0) else $error("tags not cleared");
   a_rx_enable_now: assert property (
      s_wr13 ##0 WDATA[`HFC_C1_RCV_ON] |=> RX_CLK_ON)
      else $error("receiver not running");
   a_tx_enable_now: assert property (
      s_wr13 ##0 WDATA[`HFC_C1_XMIT_ON] |=> TX_CLK_ON)
      else $error("transmitter not running");
   a_tx_off_mark: assert property (TX_BIT_EN && !TX_CLK_ON
      |=> TX_LINE) else $error("line not high while off");
   a_irq_sum_set: assert property (IRQ_EVENT ##1 s_rd14
      |=> RDATA[7]) else $error("summary bit not set");
   a_irq_sum_clear: assert property (INT_STAT_READ && !IRQ_EVENT
      ##1 (s_rd14 ##0 !IRQ_EVENT) |=> !RDATA[7])
      else $error("summary bit not cleared");
   a_ga_one_cycle: assert property (RX_GO_AHEAD
      |=> !RX_GO_AHEAD) else $error("go-ahead pulse too long");
endmodule
bind hfc_top hfc_top_chk u_hfc_top_chk (.CLK(CLK), .SYS_RST(SYS_RST),
   .ADDR(ADDR), .CS(CS), .RD(RD), .WR(WR), .WDATA(WDATA), .RDATA(RDATA),
   .IRQ_EVENT(IRQ_EVENT), .INT_STAT_READ(INT_STAT_READ),
   .RX_GO_AHEAD(RX_GO_AHEAD), .RX_CLK_ON(RX_CLK_ON),
   .TX_BIT_EN(TX_BIT_EN), .TX_LINE(TX_LINE), .TX_CLK_ON(TX_CLK_ON));

// file: sim/tb.sv
`timescale 1ns/10ps
`include "hfc_regs.vh"
module tb;
   localparam LI = 4;
   localparam LS = 12;
   reg clk, rst, cs, rd, wr, irq, isr;
   reg [4:0] addr;
   reg [7:0] wdata, d, a, b, c, z;
   reg [6:0] recog;
   reg [31:0] r;
   wire [7:0] rdata;
   wire rxb, rxe, txe, ga, rxon, txl, txon;
   integer miscompares, checked, i, k;
   always #20 clk = ~clk;
   hfc_top #(.AW(4), .TX_STAT_LEVEL(LS), .TX_INT_LEVEL(LI)) u_hfc_top (
      .CLK(clk), .SYS_RST(rst), .ADDR(addr), .CS(cs), .RD(rd), .WR(wr),
      .WDATA(wdata), .RDATA(rdata), .RECOG_ADDR(recog), .IRQ_EVENT(irq),
      .INT_STAT_READ(isr), .RX_BIT(rxb), .RX_BIT_EN(rxe),
      .RX_GO_AHEAD(ga), .RX_CLK_ON(rxon), .TX_BIT_EN(txe),
      .TX_LINE(txl), .TX_CLK_ON(txon));
   hfc_line u_hfc_line (.clk(clk), .rst(rst), .tx_line(txl), .tx_en(txe),
      .rx_en(rxe), .rx_bit(rxb));
   ////////////////////////////////////////////////////////////
   task chk(input [7:0] g, input [7:0] e);
      begin
         checked = checked + 1;
         if (g !== e) begin
            miscompares = miscompares + 1;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
         end
      end
   endtask
   // Bus tasks start at an edge and end at an edge
   task wr_reg(input [4:0] ad, input [7:0] dv);
      begin
         cs <= 1'h1;
         wr <= 1'h1;
         addr <= ad;
         wdata <= dv;
         @(posedge clk);
         cs <= 1'h0;
         wr <= 1'h0;
         @(posedge clk);
      end
   endtask
   task rd_reg(input [4:0] ad, output [7:0] dv);
      begin
         cs <= 1'h1;
         rd <= 1'h1;
         addr <= ad;
         @(posedge clk);
         cs <= 1'h0;
         rd <= 1'h0;
         #1;
         dv = rdata;
         @(posedge clk);
      end
   endtask
   task rx_chk(input [7:0] e, input [1:0] t);
      begin
         rd_reg(`HFC_ADDR_STAT, d);
         chk(d[5:4], t);
         rd_reg(`HFC_ADDR_FIFO, d);
         chk(d, e);
      end
   endtask
   task wait_ga;
      begin
         k = 0;
         while (ga !== 1'h1 && k < 3000) begin
            @(posedge clk);
            #1;
            k = k + 1;
         end
         chk(k < 3000, 1'h1);
         @(posedge clk);
      end
   endtask
   // Queue three bytes, send them, drop the enable mid-frame
   task send_frame(input [7:0] bs, input [7:0] x, y, w);
      begin
         wr_reg(`HFC_ADDR_CTRL1, bs);
         wr_reg(`HFC_ADDR_FIFO, x);
         wr_reg(`HFC_ADDR_FIFO, y);
         wr_reg(`HFC_ADDR_CTRL1, bs | 8'h10);
         wr_reg(`HFC_ADDR_FIFO, w);
         wr_reg(`HFC_ADDR_CTRL1, bs | 8'h20);
         repeat (40) @(posedge clk);
         wr_reg(`HFC_ADDR_CTRL1, bs);
         wait_ga;
         chk(txon, 1'h0);
      end
   endtask
   task count_zeros;
      begin
         z = 8'h00;
         repeat (160) begin
            @(posedge clk);
            z = z + !txl;
         end
      end
   endtask
   function [1:0] lvl(input integer n);
      lvl = (n == 0) ? `HFC_LVL_EMPTY : (n < LI) ? `HFC_LVL_LOW :
         (n < LS) ? `HFC_LVL_INT : `HFC_LVL_STAT;
   endfunction
   task end_sim;
      begin
         $display("compares %0d mismatches %0d", checked, miscompares);
         if (miscompares == 0 && checked > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      clk = 1'h0;
      rst = 1'h1;
      cs = 1'h0;
      rd = 1'h0;
      wr = 1'h0;
      irq = 1'h0;
      isr = 1'h0;
      addr = 5'h00;
      wdata = 8'h00;
      recog = 7'h00;
      miscompares = 0;
      checked = 0;
      r = $urandom(32'ha05c_40be);
      repeat (16) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      rd_reg(`HFC_ADDR_CTRL1, d);
      chk(d, `HFC_CTRL1_RST);
      rd_reg(`HFC_ADDR_STAT, d);
      chk(d[3:0], {`HFC_LVL_EMPTY, 2'h0});
      rd_reg(5'h00, d);
      chk(d, 8'h00);
      $display("done: reset");
      for (i = 0; i < 8; i = i + 1) begin
         r = $urandom;
         wr_reg(`HFC_ADDR_CTRL1, r[7:0] & 8'hfc);
         rd_reg(`HFC_ADDR_CTRL1, d);
         chk(d, r[7:0] & 8'hfc);
      end
      wr_reg(`HFC_ADDR_CTRL1, 8'h00);
      $display("done: control");
      for (i = 0; i < 18; i = i + 1) begin
         rd_reg(`HFC_ADDR_STAT, d);
         chk(d[3:2], lvl(i > 16 ? 16 : i));
         r = $urandom;
         wr_reg(`HFC_ADDR_FIFO, r[7:0]);
      end
      wr_reg(`HFC_ADDR_CTRL1, 8'h20);
      k = 0;
      d = 8'h00;
      while (d[3:2] !== `HFC_LVL_EMPTY && k < 500) begin
         rd_reg(`HFC_ADDR_STAT, d);
         k = k + 1;
      end
      chk(d[3:2], `HFC_LVL_EMPTY);
      $display("done: levels");
      wr_reg(`HFC_ADDR_CTRL1, 8'h38);
      wr_reg(`HFC_ADDR_FIFO, r[15:8]);
      rd_reg(`HFC_ADDR_CTRL1, d);
      chk(d, 8'h20);
      irq <= 1'h1;
      @(posedge clk);
      irq <= 1'h0;
      rd_reg(`HFC_ADDR_STAT, d);
      chk(d[7], 1'h1);
      isr <= 1'h1;
      @(posedge clk);
      isr <= 1'h0;
      rd_reg(`HFC_ADDR_STAT, d);
      chk(d[7], 1'h0);
      $display("done: tags and summary");
      wr_reg(`HFC_ADDR_CTRL1, 8'h60);
      repeat (200) @(posedge clk);
      count_zeros;
      chk(z, 8'h00);
      rd_reg(`HFC_ADDR_STAT, d);
      chk(d[6], 1'h1);
      wr_reg(`HFC_ADDR_CTRL1, 8'h64);
      repeat (40) @(posedge clk);
      count_zeros;
      chk(z != 8'h00, 1'h1);
      wr_reg(`HFC_ADDR_CTRL1, 8'h40);
      repeat (200) @(posedge clk);
      $display("done: idle and fill");
      r = $urandom;
      a = r[7:0];
      b = r[15:8];
      c = r[23:16];
      send_frame(8'h40, a, b, c);
      rx_chk(a, `HFC_TAG_FIRST);
      rx_chk(b, `HFC_TAG_MID);
      rx_chk(c, `HFC_TAG_GOOD);
      $display("done: frame");
      recog <= r[30:24] & 7'h3f;
      @(posedge clk);
      send_frame(8'hc0, {recog ^ 7'h01, 1'h1}, b, c);
      send_frame(8'hc0, {recog, 1'h1}, c, a);
      send_frame(8'hc0, 8'hff, a, b);
      rx_chk({recog, 1'h1}, `HFC_TAG_FIRST);
      rx_chk(c, `HFC_TAG_MID);
      rx_chk(a, `HFC_TAG_GOOD);
      rx_chk(8'hff, `HFC_TAG_FIRST);
      rx_chk(a, `HFC_TAG_MID);
      rx_chk(b, `HFC_TAG_GOOD);
      $display("done: address match");
      wr_reg(`HFC_ADDR_CTRL1, 8'h40);
      wr_reg(`HFC_ADDR_FIFO, a);
      wr_reg(`HFC_ADDR_CTRL1, 8'h50);
      wr_reg(`HFC_ADDR_FIFO, b);
      wr_reg(`HFC_ADDR_CTRL1, 8'h60);
      repeat (60) @(posedge clk);
      wr_reg(`HFC_ADDR_CTRL1, 8'h20);
      chk(rxon, 1'h1);
      repeat (400) @(posedge clk);
      chk(rxon, 1'h0);
      rx_chk(a, `HFC_TAG_FIRST);
      rx_chk(b, `HFC_TAG_GOOD);
      $display("done: receive disable");
      end_sim;
   end
   // Well beyond the expected run length
   initial begin
      repeat (40000) @(posedge clk);
      miscompares = miscompares + 1;
      end_sim;
   end
endmodule
